// ===== logic/dmaca_params.svh
// offsets, field positions, reset values and timing counts of the dma channel arbiter
`ifndef DMACA_PARAMS_SVH
`define DMACA_PARAMS_SVH

`define DMACA_NCH 4
`define DMACA_CH_BITS 2
`define DMACA_OFS_FLAGS 8'h00
`define DMACA_OFS_FCLR 8'h04
`define DMACA_OFS_CH0 8'h10
`define DMACA_SUB_CFG 2'h0
`define DMACA_SUB_CNT 2'h1
`define DMACA_SUB_PADR 2'h2
`define DMACA_SUB_MADR 2'h3

`define DMACA_CFG_EN 0
`define DMACA_CFG_TCIE 1
`define DMACA_CFG_HTIE 2
`define DMACA_CFG_TEIE 3
`define DMACA_CFG_DIR 4
`define DMACA_CFG_CIRC 5
`define DMACA_CFG_PINC 6
`define DMACA_CFG_MINC 7
`define DMACA_CFG_PSZ 8
`define DMACA_CFG_MSZ 9
`define DMACA_CFG_PRIO 10
`define DMACA_CFG_M2M 12

`define DMACA_FLG_TC 0
`define DMACA_FLG_HT 1
`define DMACA_FLG_TE 2
`define DMACA_FLG_STRIDE 4

`define DMACA_CFG_RST 13'h0000
`define DMACA_CNT_RST 16'h0000
`define DMACA_ADR_RST 32'h00000000
`define DMACA_FLAGS_RST 16'h0000

`define DMACA_ACK_CYCLES 1
`define DMACA_STEP_BYTE 32'h00000001
`define DMACA_STEP_WORD 32'h00000004

`endif

// ===== logic/dmaca_pkg.sv
// types shared by the dma channel arbiter
`default_nettype none
package dmaca_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_ACK} dmaca_state_e;
   typedef logic [12:0] dmaca_cfg_t;
   typedef logic [15:0] dmaca_cnt_t;
   typedef struct packed {
      logic we;
      logic [31:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } dmaca_mreq_s;
endpackage
`default_nettype wire

// ===== logic/dmaca_top.sv
// multi-channel dma controller with strict-priority channel arbiter
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dmaca_params.svh"

module dmaca_top (
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   output logic M_CYC_OUT,
   output logic M_STB_OUT,
   output logic M_WE_OUT,
   output logic [31:0] M_ADR_OUT,
   output logic [3:0] M_SEL_OUT,
   output logic [31:0] M_DAT_OUT,
   input wire logic [31:0] M_DAT_IN,
   input wire logic M_ACK_IN,
   input wire logic M_ERR_IN,
   input wire logic [3:0] PREQ_IN,
   output logic [3:0] PACK_OUT,
   output logic [3:0] IRQ_OUT
);

   localparam int NCH = `DMACA_NCH;

   dmaca_pkg::dmaca_cfg_t cfg_q [NCH];
   dmaca_pkg::dmaca_cfg_t cfg_d [NCH];
   dmaca_pkg::dmaca_cnt_t cnt_q [NCH];
   dmaca_pkg::dmaca_cnt_t cnt_d [NCH];
   dmaca_pkg::dmaca_cnt_t reload_q [NCH];
   dmaca_pkg::dmaca_cnt_t reload_d [NCH];
   logic [31:0] pbase_q [NCH];
   logic [31:0] pbase_d [NCH];
   logic [31:0] mbase_q [NCH];
   logic [31:0] mbase_d [NCH];
   logic [31:0] pcur_q [NCH];
   logic [31:0] pcur_d [NCH];
   logic [31:0] mcur_q [NCH];
   logic [31:0] mcur_d [NCH];
   logic [15:0] flags_q;
   logic [15:0] flags_d;
   logic [3:0] irq_q;
   logic [3:0] irq_d;
   dmaca_pkg::dmaca_state_e state_q;
   dmaca_pkg::dmaca_state_e state_d;
   logic [`DMACA_CH_BITS-1:0] ch_q;
   logic [`DMACA_CH_BITS-1:0] ch_d;
   dmaca_pkg::dmaca_mreq_s mreq_q;
   dmaca_pkg::dmaca_mreq_s mreq_d;
   logic [1:0] lane_q;
   logic [1:0] lane_d;
   logic [1:0] ack_ctr_q;
   logic [1:0] ack_ctr_d;
   logic wb_ack_q;
   logic wb_ack_d;
   logic [31:0] wb_dat_q;
   logic [31:0] wb_dat_d;

   logic [NCH-1:0] pend;
   logic gnt_valid;
   logic [`DMACA_CH_BITS-1:0] gnt_ch;
   logic [1:0] gnt_prio;

   // byte-enable merge of a bus write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // address step per item: a byte item walks byte addresses so bytes pack into words
   function automatic logic [31:0] step(input logic narrow);
      return narrow ? `DMACA_STEP_BYTE : `DMACA_STEP_WORD;
   endfunction

   // a hardware request from same-clock peripheral logic needs no synchroniser
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         pend[i] = cfg_q[i][`DMACA_CFG_EN] && (cnt_q[i] != 16'h0000)
                   && (cfg_q[i][`DMACA_CFG_M2M] || PREQ_IN[i]);
      end
   end

   // ascending scan with strict greater-than keeps the lower number on a tie; no rotation state at all
   always_comb begin
      gnt_valid = 1'b0;
      gnt_ch = '0;
      gnt_prio = 2'h0;
      for (int i = 0; i < NCH; i++) begin
         if (pend[i] && (!gnt_valid || cfg_q[i][`DMACA_CFG_PRIO +: 2] > gnt_prio)) begin
            gnt_valid = 1'b1;
            gnt_ch = `DMACA_CH_BITS'(i);
            gnt_prio = cfg_q[i][`DMACA_CFG_PRIO +: 2];
         end
      end
   end

   always_comb begin
      logic narrow;
      logic dir;
      logic [31:0] src;
      logic [31:0] dst;
      logic [7:0] item;
      logic [15:0] cnt_new;
      logic [15:0] set_v;
      logic [15:0] clr_v;
      logic wb_req;
      logic [3:0] wgrp;
      logic [`DMACA_CH_BITS-1:0] wch;
      logic wch_ok;
      dmaca_pkg::dmaca_cfg_t cfg_w;
      narrow = 1'b0;
      dir = 1'b0;
      src = 32'h00000000;
      dst = 32'h00000000;
      item = 8'h00;
      cnt_new = 16'h0000;
      set_v = 16'h0000;
      clr_v = 16'h0000;
      cfg_w = '0;
      wb_req = WB_CYC_IN && WB_STB_IN && !wb_ack_q;
      wgrp = WB_ADR_IN[7:4];
      wch = `DMACA_CH_BITS'(wgrp - 4'h1);
      wch_ok = (wgrp >= 4'h1) && (wgrp <= 4'(NCH));
      cfg_d = cfg_q;
      cnt_d = cnt_q;
      reload_d = reload_q;
      pbase_d = pbase_q;
      mbase_d = mbase_q;
      pcur_d = pcur_q;
      mcur_d = mcur_q;
      state_d = state_q;
      ch_d = ch_q;
      mreq_d = mreq_q;
      lane_d = lane_q;
      ack_ctr_d = ack_ctr_q;
      narrow = ~cfg_q[ch_q][`DMACA_CFG_PSZ] | ~cfg_q[ch_q][`DMACA_CFG_MSZ];
      dir = cfg_q[ch_q][`DMACA_CFG_DIR];
      unique case (state_q)
         dmaca_pkg::ST_IDLE: begin
            if (gnt_valid) begin
               ch_d = gnt_ch;
               src = cfg_q[gnt_ch][`DMACA_CFG_DIR] ? mcur_q[gnt_ch] : pcur_q[gnt_ch];
               mreq_d.we = 1'b0;
               mreq_d.adr = {src[31:2], 2'b00};
               mreq_d.sel = 4'hf;
               mreq_d.dat = 32'h00000000;
               lane_d = src[1:0];
               state_d = dmaca_pkg::ST_RD;
            end
         end
         dmaca_pkg::ST_RD: begin
            if (M_ERR_IN) begin
               set_v[`DMACA_FLG_STRIDE*ch_q + `DMACA_FLG_TE] = 1'b1;
               cfg_d[ch_q][`DMACA_CFG_EN] = 1'b0;
               state_d = dmaca_pkg::ST_IDLE;
            end else if (M_ACK_IN) begin
               item = 8'(M_DAT_IN >> {lane_q, 3'b000});
               dst = dir ? pcur_q[ch_q] : mcur_q[ch_q];
               mreq_d.we = 1'b1;
               mreq_d.adr = {dst[31:2], 2'b00};
               if (narrow) begin
                  mreq_d.sel = 4'(4'h1 << dst[1:0]);
                  mreq_d.dat = {4{item}};
               end else begin
                  mreq_d.sel = 4'hf;
                  mreq_d.dat = M_DAT_IN;
               end
               state_d = dmaca_pkg::ST_WR;
            end
         end
         dmaca_pkg::ST_WR: begin
            if (M_ERR_IN) begin
               set_v[`DMACA_FLG_STRIDE*ch_q + `DMACA_FLG_TE] = 1'b1;
               cfg_d[ch_q][`DMACA_CFG_EN] = 1'b0;
               state_d = dmaca_pkg::ST_IDLE;
            end else if (M_ACK_IN) begin
               cnt_new = cnt_q[ch_q] - 16'h0001;
               cnt_d[ch_q] = cnt_new;
               if (cfg_q[ch_q][`DMACA_CFG_PINC]) begin
                  pcur_d[ch_q] = pcur_q[ch_q] + step(narrow);
               end
               if (cfg_q[ch_q][`DMACA_CFG_MINC]) begin
                  mcur_d[ch_q] = mcur_q[ch_q] + step(narrow);
               end
               if (cnt_new == {1'b0, reload_q[ch_q][15:1]}) begin
                  set_v[`DMACA_FLG_STRIDE*ch_q + `DMACA_FLG_HT] = 1'b1;
               end
               if (cnt_new == 16'h0000) begin
                  set_v[`DMACA_FLG_STRIDE*ch_q + `DMACA_FLG_TC] = 1'b1;
                  if (cfg_q[ch_q][`DMACA_CFG_CIRC]) begin
                     cnt_d[ch_q] = reload_q[ch_q];
                     pcur_d[ch_q] = pbase_q[ch_q];
                     mcur_d[ch_q] = mbase_q[ch_q];
                  end else begin
                     cfg_d[ch_q][`DMACA_CFG_EN] = 1'b0;
                  end
               end
               if (cfg_q[ch_q][`DMACA_CFG_M2M]) begin
                  state_d = dmaca_pkg::ST_IDLE;
               end else begin
                  ack_ctr_d = 2'(`DMACA_ACK_CYCLES - 1);
                  state_d = dmaca_pkg::ST_ACK;
               end
            end
         end
         dmaca_pkg::ST_ACK: begin
            if (ack_ctr_q == 2'h0) begin
               state_d = dmaca_pkg::ST_IDLE;
            end else begin
               ack_ctr_d = ack_ctr_q - 2'h1;
            end
         end
      endcase
      // register slave: one access per request, acked the cycle after it is seen
      wb_ack_d = wb_req;
      wb_dat_d = wb_dat_q;
      if (wb_req) begin
         wb_dat_d = 32'h00000000;
         if (WB_ADR_IN == `DMACA_OFS_FLAGS) begin
            wb_dat_d = {16'h0000, flags_q};
         end else if (wch_ok) begin
            unique case (WB_ADR_IN[3:2])
               `DMACA_SUB_CFG: wb_dat_d = {19'h00000, cfg_q[wch]};
               `DMACA_SUB_CNT: wb_dat_d = {16'h0000, cnt_q[wch]};
               `DMACA_SUB_PADR: wb_dat_d = pbase_q[wch];
               `DMACA_SUB_MADR: wb_dat_d = mbase_q[wch];
            endcase
         end
         if (WB_WE_IN) begin
            if (WB_ADR_IN == `DMACA_OFS_FCLR) begin
               clr_v = 16'(merge(32'h00000000, WB_DAT_IN, WB_SEL_IN));
            end else if (wch_ok) begin
               unique case (WB_ADR_IN[3:2])
                  `DMACA_SUB_CFG: begin
                     cfg_w = 13'(merge({19'h00000, cfg_q[wch]}, WB_DAT_IN, WB_SEL_IN));
                     cfg_d[wch] = cfg_w;
                     if (cfg_w[`DMACA_CFG_EN] && !cfg_q[wch][`DMACA_CFG_EN]) begin
                        cnt_d[wch] = reload_q[wch];
                        pcur_d[wch] = pbase_q[wch];
                        mcur_d[wch] = mbase_q[wch];
                     end
                  end
                  `DMACA_SUB_CNT: begin
                     reload_d[wch] = 16'(merge({16'h0000, reload_q[wch]}, WB_DAT_IN, WB_SEL_IN));
                     cnt_d[wch] = reload_d[wch];
                  end
                  `DMACA_SUB_PADR: begin
                     pbase_d[wch] = merge(pbase_q[wch], WB_DAT_IN, WB_SEL_IN);
                     pcur_d[wch] = pbase_d[wch];
                  end
                  `DMACA_SUB_MADR: begin
                     mbase_d[wch] = merge(mbase_q[wch], WB_DAT_IN, WB_SEL_IN);
                     mcur_d[wch] = mbase_d[wch];
                  end
               endcase
            end
         end
      end
      // a flag raised in the same cycle as its clear survives
      flags_d = (flags_q & ~clr_v) | set_v;
      for (int i = 0; i < NCH; i++) begin
         irq_d[i] = |(flags_d[`DMACA_FLG_STRIDE*i +: 3] & cfg_d[i][`DMACA_CFG_TEIE:`DMACA_CFG_TCIE]);
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         for (int i = 0; i < NCH; i++) begin
            cfg_q[i] <= `DMACA_CFG_RST;
            cnt_q[i] <= `DMACA_CNT_RST;
            reload_q[i] <= `DMACA_CNT_RST;
            pbase_q[i] <= `DMACA_ADR_RST;
            mbase_q[i] <= `DMACA_ADR_RST;
            pcur_q[i] <= `DMACA_ADR_RST;
            mcur_q[i] <= `DMACA_ADR_RST;
         end
         flags_q <= `DMACA_FLAGS_RST;
         irq_q <= 4'h0;
         state_q <= dmaca_pkg::ST_IDLE;
         ch_q <= '0;
         mreq_q <= '0;
         lane_q <= 2'h0;
         ack_ctr_q <= 2'h0;
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h00000000;
      end else begin
         cfg_q <= cfg_d;
         cnt_q <= cnt_d;
         reload_q <= reload_d;
         pbase_q <= pbase_d;
         mbase_q <= mbase_d;
         pcur_q <= pcur_d;
         mcur_q <= mcur_d;
         flags_q <= flags_d;
         irq_q <= irq_d;
         state_q <= state_d;
         ch_q <= ch_d;
         mreq_q <= mreq_d;
         lane_q <= lane_d;
         ack_ctr_q <= ack_ctr_d;
         wb_ack_q <= wb_ack_d;
         wb_dat_q <= wb_dat_d;
      end
   end

   assign WB_ACK_OUT = wb_ack_q;
   assign WB_DAT_OUT = wb_dat_q;
   assign M_CYC_OUT = (state_q == dmaca_pkg::ST_RD) || (state_q == dmaca_pkg::ST_WR);
   assign M_STB_OUT = M_CYC_OUT;
   assign M_WE_OUT = mreq_q.we;
   assign M_ADR_OUT = mreq_q.adr;
   assign M_SEL_OUT = mreq_q.sel;
   assign M_DAT_OUT = mreq_q.dat;
   assign PACK_OUT = (state_q == dmaca_pkg::ST_ACK) ? 4'(4'h1 << ch_q) : 4'h0;
   assign IRQ_OUT = irq_q;

endmodule
`default_nettype wire

// ===== bench/dmaca_chk.sv
// concurrent checks on the ports of the dma channel arbiter
`timescale 1ns/1ps
`default_nettype none
module dmaca_chk (
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_ACK_OUT,
   input wire logic M_CYC_OUT,
   input wire logic M_STB_OUT,
   input wire logic M_WE_OUT,
   input wire logic [31:0] M_ADR_OUT,
   input wire logic [3:0] M_SEL_OUT,
   input wire logic [31:0] M_DAT_OUT,
   input wire logic M_ACK_IN,
   input wire logic M_ERR_IN,
   input wire logic [3:0] PACK_OUT
);
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);
   a_wb_ack_once: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
      else $error("register ack not a single cycle");
   a_pack_onehot: assert property ($onehot0(PACK_OUT))
      else $error("more than one channel acknowledged");
   a_word_aligned: assert property (M_STB_OUT |-> M_CYC_OUT && M_ADR_OUT[1:0] == 2'h0)
      else $error("data access not a whole word");
   a_hold_access: assert property (M_STB_OUT && !M_ACK_IN && !M_ERR_IN |=> M_STB_OUT && $stable(M_ADR_OUT)
      && $stable(M_WE_OUT) && $stable(M_DAT_OUT))
      else $error("data access changed before answer");
   a_read_then_write: assert property (M_STB_OUT && !M_WE_OUT && M_ACK_IN && !M_ERR_IN |=> M_STB_OUT && M_WE_OUT)
      else $error("read not followed by write");
   a_byte_lanes: assert property (M_STB_OUT && M_WE_OUT && M_SEL_OUT != 4'hf |->
      $onehot(M_SEL_OUT) && M_DAT_OUT == {4{M_DAT_OUT[7:0]}})
      else $error("byte write lanes wrong");
   a_rearb_gap: assert property (M_STB_OUT && M_WE_OUT && (M_ACK_IN || M_ERR_IN) |=> !M_STB_OUT)
      else $error("no arbitration gap after item");
   // the close cycle is what keeps a slow peripheral from being served twice
   a_ack_close: assert property (PACK_OUT != 4'h0 |-> $past(M_ACK_IN) && $past(M_WE_OUT) && !M_CYC_OUT
      ##1 !M_CYC_OUT && PACK_OUT == 4'h0)
      else $error("acknowledge phase wrong");
   a_err_abort: assert property (M_STB_OUT && M_ERR_IN |=> !M_CYC_OUT && PACK_OUT == 4'h0)
      else $error("error did not abort item");
   c_hw_item: cover property (PACK_OUT != 4'h0);
   c_error: cover property (M_STB_OUT && M_ERR_IN);
   c_byte: cover property (M_STB_OUT && M_WE_OUT && M_SEL_OUT != 4'hf);
endmodule
`default_nettype wire

// ===== bench/dmaca_mem.sv
// bus slave memory and requesting peripherals on the dma master port
`timescale 1ns/1ps
`default_nettype none
module dmaca_mem (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic stb_in,
   input wire logic we_in,
   input wire logic [31:0] adr_in,
   input wire logic [3:0] sel_in,
   input wire logic [31:0] dat_in,
   input wire logic [1:0] slow_in,
   input wire logic [3:0] want_in,
   input wire logic [3:0] pack_in,
   output logic [31:0] dat_out,
   output logic ack_out,
   output logic err_out,
   output logic [3:0] preq_out
);
   logic [31:0] mem [64];
   logic [7:0] cnt_q;
   logic [1:0] wt_q;
   logic hit;
   // wait states hold the master in mid access
   assign hit = stb_in && !ack_out && !err_out && wt_q == slow_in;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ack_out <= 1'b0;
         err_out <= 1'b0;
         wt_q <= 2'h0;
         cnt_q <= 8'h00;
         preq_out <= 4'h0;
         dat_out <= 32'h0;
      end else begin
         ack_out <= hit && !adr_in[10];
         err_out <= hit && adr_in[10];
         wt_q <= (stb_in && !hit && !ack_out && !err_out) ? wt_q + 2'h1 : 2'h0;
         // idle read data toggles so a stale sample never looks valid
         dat_out <= !hit ? ~dat_out : adr_in[8] ? {4{cnt_q}} : mem[adr_in[7:2]];
         if (ack_out && !we_in && adr_in[8]) cnt_q <= cnt_q + 8'h01;
         for (int i = 0; i < 4; i++) if (ack_out && we_in && sel_in[i]) mem[adr_in[7:2]][8*i+:8] <= dat_in[8*i+:8];
         preq_out <= want_in & ~pack_in;
      end
   end
endmodule
`default_nettype wire

// ===== bench/dmaca_top_tb.sv
// self-checking bench for the dma channel arbiter
`timescale 1ns/1ps
`default_nettype none
module dmaca_top_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, m_adr, m_dat, m_rdat;
   logic ack, m_cyc, m_stb, m_we, m_ack, m_err;
   logic [3:0] m_sel, preq, pack, irq;
   logic [3:0] want = 4'h0;
   logic [1:0] slow = 2'h0;
   logic [31:0] rd_q [$];
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   dmaca_top dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .M_CYC_OUT(m_cyc), .M_STB_OUT(m_stb), .M_WE_OUT(m_we), .M_ADR_OUT(m_adr), .M_SEL_OUT(m_sel),
      .M_DAT_OUT(m_dat), .M_DAT_IN(m_rdat), .M_ACK_IN(m_ack), .M_ERR_IN(m_err), .PREQ_IN(preq),
      .PACK_OUT(pack), .IRQ_OUT(irq));
   dmaca_mem mdl_u (.clk_in(clk), .rst_n_in(rst_n), .stb_in(m_stb), .we_in(m_we), .adr_in(m_adr),
      .sel_in(m_sel), .dat_in(m_dat), .slow_in(slow), .want_in(want), .pack_in(pack), .dat_out(m_rdat),
      .ack_out(m_ack), .err_out(m_err), .preq_out(preq));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (m_stb && !m_we && m_ack) rd_q.push_back(m_adr);
      if (cycles > 5000) begin
         n_errors++;
         wrap_up;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // only the global cycle limit ends a wait for ack
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, e, q);
      chk(q, e);
   endtask
   task automatic wait_irq(input logic [3:0] m);
      while ((irq & m) !== m) @(posedge clk);
   endtask
   task automatic t_regs;
      rd(8'h00, 32'h0);
      rd(8'h10, 32'h0);
      wr(8'h44, 32'h1ffff);
      rd(8'h44, 32'hffff);
      wr(8'hfc, 32'hffffffff);
      rd(8'hfc, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_pack;
      wr(8'h14, 32'h4);
      wr(8'h18, 32'h100);
      wr(8'h1c, 32'h0);
      wr(8'h10, 32'h83);
      want <= 4'h1;
      wait_irq(4'h1);
      want <= 4'h0;
      chk(mdl_u.mem[0], 32'h03020100);
      rd(8'h00, 32'h3);
      rd(8'h14, 32'h0);
      rd(8'h10, 32'h82);
      wr(8'h04, 32'h7);
      rd(8'h00, 32'h0);
      chk({28'h0, irq}, 32'h0);
      $display("test pack done");
   endtask
   // memory to peripheral: bytes come from successive lanes of one word into a fixed byte port
   task automatic t_unpack;
      wr(8'h14, 32'h3);
      wr(8'h18, 32'hf0);
      wr(8'h1c, 32'h0);
      wr(8'h10, 32'h1093);
      wait_irq(4'h1);
      chk({24'h000000, mdl_u.mem[6'h3c][7:0]}, 32'h2);
      rd(8'h00, 32'h3);
      rd(8'h10, 32'h1092);
      wr(8'h04, 32'h3);
      $display("test unpack done");
   endtask
   task automatic t_prio;
      logic [7:0] b;
      logic [31:0] cf [4] = '{32'hf82, 32'h783, 32'hf83, 32'hf83};
      logic [31:0] e [6] = '{32'h130, 32'h140, 32'h130, 32'h140, 32'h120, 32'h120};
      slow <= 2'h2;
      rd_q.delete();
      for (b = 8'h10; b < 8'h50; b += 8'h10) begin
         wr(b + 8'h4, 32'h2);
         wr(b + 8'h8, 32'h100 + {24'h0, b});
         wr(b + 8'hc, {24'h0, b});
         wr(b, cf[b[7:4] - 4'h1]);
      end
      want <= 4'hf;
      wait_irq(4'he);
      want <= 4'h0;
      chk(32'(rd_q.size()), 32'h6);
      for (int i = 0; i < 6; i++) chk(rd_q[i], e[i]);
      chk({28'h0, irq}, 32'he);
      wr(8'h04, 32'hffff);
      $display("test prio done");
   endtask
   task automatic t_circ;
      int n;
      n = 0;
      slow <= 2'h0;
      wr(8'h24, 32'h2);
      wr(8'h28, 32'h100);
      wr(8'h2c, 32'h0);
      wr(8'h20, 32'h3a1);
      want <= 4'h2;
      while (n < 3) begin
         @(posedge clk);
         if (pack[1] === 1'b1) n++;
      end
      want <= 4'h0;
      rd(8'h24, 32'h1);
      rd(8'h20, 32'h3a1);
      rd(8'h2c, 32'h0);
      rd(8'h00, 32'h30);
      wr(8'h20, 32'h0);
      wr(8'h04, 32'hffff);
      $display("test circ done");
   endtask
   task automatic t_err;
      wr(8'h14, 32'h1);
      wr(8'h18, 32'h400);
      wr(8'h10, 32'h1009);
      wait_irq(4'h1);
      rd(8'h00, 32'h4);
      rd(8'h10, 32'h1008);
      wr(8'h04, 32'h4);
      rd(8'h00, 32'h0);
      $display("test err done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_pack;
      t_unpack;
      t_prio;
      t_circ;
      t_err;
      wrap_up;
   end
endmodule
bind dmaca_top dmaca_chk chk_u (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .WB_CYC_IN(WB_CYC_IN),
   .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT), .M_CYC_OUT(M_CYC_OUT), .M_STB_OUT(M_STB_OUT),
   .M_WE_OUT(M_WE_OUT), .M_ADR_OUT(M_ADR_OUT), .M_SEL_OUT(M_SEL_OUT), .M_DAT_OUT(M_DAT_OUT),
   .M_ACK_IN(M_ACK_IN), .M_ERR_IN(M_ERR_IN), .PACK_OUT(PACK_OUT));
`default_nettype wire
